// file: hdl/pgm_params.svh
// Summary of operation
// R1: two role-select words choose primary or secondary
// R2: pin0 secondary: power-off, request two, enable one
// R3: pin1 secondary: reset, warm restart, supply, request one (request one has no route here, held low)
// R4: pin2 secondary: request two or scaling data
// R5: pin3 secondary: enable one or converter sync
// R6: pin4 secondary: enable two or scaling clock/select
// R7: pin5 secondary: keep-on input or enable three
// R8: pin6 secondary: low-power request, rails valid, enable three
// R9: per-pin rise/fall/both interrupts, individually masked
// R10: no pin interrupt when pin in secondary role
// R11: any pin event counts as wake-up
// R12: pins two and four never switch-on from off
// R13: enable outputs driven by power-up sequence step
// R14: per-pin direction setting, read and write
// R15: input-data shows input pin levels
// R16: output-data register holds driven levels
// R17: write-only set and clear force bits
// R18: per-pin debounce enable
// R19: global enable for all general-purpose pins
// R20: two pull config words per line
// R21: per-pin open-drain selection
// R22: secondary pins use separate pull and drive settings
// R23: separate rise and fall edge enables
// R24: set/clear ones touch only their bits
// R25: pin inputs synchronised before use
`ifndef PGM_PARAMS_SVH
`define PGM_PARAMS_SVH
`define PGM_NPINS 7
`define PGM_DEB_CYCLES 16'h03e8
`define PGM_PIN_I2_MASK 7'h14
`define PGM_SEL_W 2
`define PGM_SEL_GPIO 2'h0
`define PGM_SEL_ALT1 2'h1
`define PGM_SEL_ALT2 2'h2
`define PGM_SEL_ALT3 2'h3
`endif

// file: hdl/pgm_pkg.sv
package pgm_pkg;
	typedef logic [6:0] pgm_pins_t;
	typedef enum logic [1:0] {
		PGM_DB_IDLE = 2'h0,
		PGM_DB_WAIT = 2'h1,
		PGM_DB_TAKE = 2'h3
	} pgm_db_e;
endpackage

// file: hdl/pgm_sync_if.sv
`timescale 1ns/1ps
interface pgm_sync_if;
	logic [6:0] raw;
	logic [6:0] clean;
	logic [6:0] filt_en;
	modport src (input clean, output raw, output filt_en);
	modport flt (input raw, input filt_en, output clean);
endinterface

// file: hdl/pgm_filter.sv
`timescale 1ns/1ps
`include "pgm_params.svh"
module pgm_filter (
	input wire logic i_clk,
	input wire logic i_rst,
	pgm_sync_if.flt sif
);
	logic [6:0] s1_r;
	logic [6:0] s2_r;
	logic [6:0] out_r;
	logic [15:0] cnt_r [0:6];
	pgm_pkg::pgm_db_e st_r [0:6];
	// R25 two-flop synchroniser, first stage read only by second
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s1_r <= 7'h00;
			s2_r <= 7'h00;
		end else begin
			s1_r <= sif.raw;
			s2_r <= s1_r;
		end
	end
	// R18 per-pin debounce: level must hold a full interval
	always_ff @(posedge i_clk) begin
		for (int i = 0; i < `PGM_NPINS; i++) begin
			if (i_rst) begin
				out_r[i] <= 1'b0;
				cnt_r[i] <= 16'h0000;
				st_r[i] <= pgm_pkg::PGM_DB_IDLE;
			end else if (!sif.filt_en[i]) begin
				out_r[i] <= s2_r[i];
				cnt_r[i] <= 16'h0000;
				st_r[i] <= pgm_pkg::PGM_DB_IDLE;
			end else begin
				case (st_r[i])
				pgm_pkg::PGM_DB_IDLE: begin
					cnt_r[i] <= 16'h0000;
					if (s2_r[i] != out_r[i])
						st_r[i] <= pgm_pkg::PGM_DB_WAIT;
				end
				pgm_pkg::PGM_DB_WAIT: begin
					if (s2_r[i] == out_r[i])
						st_r[i] <= pgm_pkg::PGM_DB_IDLE;
					else if (cnt_r[i] == `PGM_DEB_CYCLES)
						st_r[i] <= pgm_pkg::PGM_DB_TAKE;
					else
						cnt_r[i] <= cnt_r[i] + 16'h0001;
				end
				pgm_pkg::PGM_DB_TAKE: begin
					out_r[i] <= s2_r[i];
					st_r[i] <= pgm_pkg::PGM_DB_IDLE;
				end
				default: st_r[i] <= pgm_pkg::PGM_DB_IDLE;
				endcase
			end
		end
	end
	// while filtering, the output may move only out of the take state
	AST_DEB_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // R18
		(sif.filt_en[0] && st_r[0] != pgm_pkg::PGM_DB_TAKE) |=> $stable(out_r[0]))
		else $error("debounced level moved early");
	assign sif.clean = out_r;
endmodule

// file: hdl/pgm_edge.sv
`timescale 1ns/1ps
module pgm_edge (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [6:0] i_level,
	input wire logic [6:0] i_rise_en,
	input wire logic [6:0] i_fall_en,
	output logic [6:0] o_event
);
	logic [6:0] prev_r;
	always_ff @(posedge i_clk) begin
		if (i_rst)
			prev_r <= 7'h00;
		else
			prev_r <= i_level;
	end
	// R23 independent rise and fall enables
	always_comb begin
		o_event = (i_level & ~prev_r & i_rise_en) | (~i_level & prev_r & i_fall_en);
	end
endmodule

// file: hdl/pgm_gpio_pin_mux.sv
`timescale 1ns/1ps
`include "pgm_params.svh"
module pgm_gpio_pin_mux (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [6:0] i_pad_in,
	output logic [6:0] o_pad_out,
	output logic [6:0] o_pad_oe,
	output logic [6:0] o_pad_pull_up,
	output logic [6:0] o_pad_pull_down,
	input wire logic [6:0] i_pad_role_select_a,
	input wire logic [6:0] i_pad_role_select_b,
	input wire logic i_pin_direction_we,
	input wire logic [6:0] i_pin_direction_wd,
	output logic [6:0] o_pin_direction,
	output logic [6:0] o_data_in,
	input wire logic i_data_out_we,
	input wire logic [6:0] i_data_out_wd,
	output logic [6:0] o_data_out,
	input wire logic i_data_set_we,
	input wire logic i_data_clr_we,
	input wire logic [6:0] i_data_setclr_wd,
	input wire logic [6:0] i_pin_filter_enable,
	input wire logic i_gpio_global_en,
	input wire logic [6:0] i_pin_pull_config_a,
	input wire logic [6:0] i_pin_pull_config_b,
	input wire logic [6:0] i_pin_opendrain_select,
	input wire logic [6:0] i_alt_pull_up,
	input wire logic [6:0] i_alt_pull_down,
	input wire logic [6:0] i_alt_opendrain,
	input wire logic [6:0] i_irq_rise_edge_select,
	input wire logic [6:0] i_irq_fall_edge_select,
	input wire logic [6:0] i_irq_mask,
	input wire logic i_off_mode,
	output logic [6:0] o_pin_irq,
	output logic o_wake_event,
	output logic o_switch_on_req,
	input wire logic i_ext_reg_enable_one,
	input wire logic i_ext_reg_enable_two,
	input wire logic i_ext_reg_enable_three,
	input wire logic i_rails_valid_out,
	input wire logic i_scaling_port_data_out,
	input wire logic i_scaling_port_data_oe,
	input wire logic i_scaling_port_clk_sel_out,
	input wire logic i_scaling_port_clk_sel_oe,
	output logic o_scaling_port_data_in,
	output logic o_scaling_port_clk_sel_in,
	output logic o_power_off_request_in,
	output logic o_periph_power_req_one,
	output logic o_periph_power_req_two,
	output logic o_reset_in,
	output logic o_warm_restart_in_n,
	output logic o_usb_supply_detect_in,
	output logic o_converter_sync_clk_in,
	output logic o_supply_keep_on_in,
	output logic o_low_power_request_n
);
	pgm_sync_if sif ();
	logic [6:0] dir_r;
	logic [6:0] dout_r;
	logic [6:0] din_r;
	logic [6:0] irq_r;
	logic wake_r;
	logic on_r;
	logic [6:0] evt;
	logic [6:0] is_gpio;
	logic [6:0] alt_out;
	logic [6:0] alt_oe;
	logic [1:0] sel [0:6];

	function automatic logic [1:0] role_of(input logic [6:0] a, input logic [6:0] b,
		input int i);
		role_of = {b[i], a[i]};
	endfunction

	// R1 role per pin from the two select words
	always_comb begin
		for (int i = 0; i < `PGM_NPINS; i++) begin
			sel[i] = role_of(i_pad_role_select_a, i_pad_role_select_b, i);
			is_gpio[i] = (sel[i] == `PGM_SEL_GPIO);
		end
	end

	assign sif.raw = i_pad_in;
	// R22 the filter enable is a primary-role control, so secondary inputs bypass it
	assign sif.filt_en = i_pin_filter_enable & is_gpio;

	pgm_filter u_filter (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.sif(sif)
	);

	pgm_edge u_edge (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_level(sif.clean),
		.i_rise_en(i_irq_rise_edge_select),
		.i_fall_en(i_irq_fall_edge_select),
		.o_event(evt)
	);
	AST_EDGE_SEL: assert property (@(posedge i_clk) disable iff (i_rst) // R23
		(i_irq_rise_edge_select == 7'h00 && i_irq_fall_edge_select == 7'h00)
		|-> (evt == 7'h00))
		else $error("edge event with no edge selected");

	// R14 direction register
	always_ff @(posedge i_clk) begin
		if (i_rst)
			dir_r <= 7'h00;
		else if (i_pin_direction_we)
			dir_r <= i_pin_direction_wd;
	end

	// R16 R17 R24 output data with bitwise set/clear; set beats clear
	always_ff @(posedge i_clk) begin
		if (i_rst)
			dout_r <= 7'h00;
		else if (i_data_out_we)
			dout_r <= i_data_out_wd;
		else if (i_data_set_we)
			dout_r <= dout_r | i_data_setclr_wd;
		else if (i_data_clr_we)
			dout_r <= dout_r & ~i_data_setclr_wd;
	end
	AST_DOUT_WR: assert property (@(posedge i_clk) disable iff (i_rst) // R16
		i_data_out_we |=> (o_data_out == $past(i_data_out_wd)))
		else $error("output data not written");
	AST_SET: assert property (@(posedge i_clk) disable iff (i_rst) // R17
		(i_data_set_we && !i_data_out_we) |=>
		((o_data_out & $past(i_data_setclr_wd)) == $past(i_data_setclr_wd)))
		else $error("set failed");

	// R15 input data for input pins only, others read zero
	always_ff @(posedge i_clk) begin
		if (i_rst)
			din_r <= 7'h00;
		else
			din_r <= sif.clean & ~dir_r & is_gpio;
	end
	// output pins read zero so software never mistakes its own drive for input
	AST_DIN_OUT: assert property (@(posedge i_clk) disable iff (i_rst) // R15
		(dir_r != 7'h00) |=> ((o_data_in & $past(dir_r)) == 7'h00))
		else $error("input data shows an output pin");

	// R9 R10 R19 masked pin interrupts in primary role only
	always_ff @(posedge i_clk) begin
		if (i_rst)
			irq_r <= 7'h00;
		else
			irq_r <= evt & ~i_irq_mask & is_gpio & {7{i_gpio_global_en}};
	end
	// masked events are dropped, not held, so a later unmask raises nothing stale
	AST_MASK: assert property (@(posedge i_clk) disable iff (i_rst) // R9
		(i_irq_mask != 7'h00) |=> ((o_pin_irq & $past(i_irq_mask)) == 7'h00))
		else $error("masked line raised an interrupt");
	AST_IRQ_EVT: assert property (@(posedge i_clk) disable iff (i_rst) // R9
		(evt == 7'h00) |=> (o_pin_irq == 7'h00))
		else $error("interrupt without an edge");
	AST_NOALTIRQ_ALL: assert property (@(posedge i_clk) disable iff (i_rst) // R10
		(is_gpio != 7'h7f) |=> ((o_pin_irq & ~$past(is_gpio)) == 7'h00))
		else $error("secondary pin raised an interrupt");

	// R11 R12 wake on any pin event; pins two and four excluded from off
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wake_r <= 1'b0;
			on_r <= 1'b0;
		end else begin
			wake_r <= |evt;
			on_r <= i_off_mode ? |(evt & ~`PGM_PIN_I2_MASK) : |evt;
		end
	end
	AST_SWON: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		(!i_off_mode && (evt != 7'h00)) |=> o_switch_on_req)
		else $error("event outside off mode gave no switch-on");

	// R2 R3 R4 R5 R6 R7 R8 R13 secondary output drive
	always_comb begin
		alt_out = 7'h00;
		alt_oe = 7'h00;
		if (sel[0] == `PGM_SEL_ALT3) begin
			alt_out[0] = i_ext_reg_enable_one;
			alt_oe[0] = 1'b1;
		end
		if (sel[2] == `PGM_SEL_ALT2) begin
			alt_out[2] = i_scaling_port_data_out;
			alt_oe[2] = i_scaling_port_data_oe;
		end
		if (sel[3] == `PGM_SEL_ALT1) begin
			alt_out[3] = i_ext_reg_enable_one;
			alt_oe[3] = 1'b1;
		end
		if (sel[4] == `PGM_SEL_ALT1) begin
			alt_out[4] = i_ext_reg_enable_two;
			alt_oe[4] = 1'b1;
		end else if (sel[4] == `PGM_SEL_ALT2) begin
			alt_out[4] = i_scaling_port_clk_sel_out;
			alt_oe[4] = i_scaling_port_clk_sel_oe;
		end
		if (sel[5] == `PGM_SEL_ALT2) begin
			alt_out[5] = i_ext_reg_enable_three;
			alt_oe[5] = 1'b1;
		end
		if (sel[6] == `PGM_SEL_ALT2) begin
			alt_out[6] = i_rails_valid_out;
			alt_oe[6] = 1'b1;
		end else if (sel[6] == `PGM_SEL_ALT3) begin
			alt_out[6] = i_ext_reg_enable_three;
			alt_oe[6] = 1'b1;
		end
	end

	// secondary inputs read the synchronised level; default to idle level when unselected
	always_comb begin
		o_power_off_request_in = (sel[0] == `PGM_SEL_ALT1) & sif.clean[0];
		o_periph_power_req_two = ((sel[0] == `PGM_SEL_ALT2) & sif.clean[0])
			| ((sel[2] == `PGM_SEL_ALT1) & sif.clean[2]);
		o_reset_in = (sel[1] == `PGM_SEL_ALT1) & sif.clean[1];
		o_warm_restart_in_n = (sel[1] == `PGM_SEL_ALT2) ? sif.clean[1] : 1'b1;
		o_usb_supply_detect_in = (sel[1] == `PGM_SEL_ALT3) & sif.clean[1];
		// two select bits leave room for three alternates, so request one has no route
		o_periph_power_req_one = 1'b0;
		o_scaling_port_data_in = (sel[2] == `PGM_SEL_ALT2) ? sif.clean[2] : 1'b1;
		o_converter_sync_clk_in = (sel[3] == `PGM_SEL_ALT2) & sif.clean[3];
		o_scaling_port_clk_sel_in = (sel[4] == `PGM_SEL_ALT2) ? sif.clean[4] : 1'b1;
		o_supply_keep_on_in = (sel[5] == `PGM_SEL_ALT1) & sif.clean[5];
		o_low_power_request_n = (sel[6] == `PGM_SEL_ALT1) ? sif.clean[6] : 1'b1;
	end
	// with open drain the pad only sinks, so the drive checks leave it out
	AST_PWROFF: assert property (@(posedge i_clk) disable iff (i_rst) // R2
		(sel[0] == `PGM_SEL_ALT1) |-> (o_power_off_request_in == sif.clean[0]))
		else $error("power-off input not routed");
	AST_PIN0_EXTEN: assert property (@(posedge i_clk) disable iff (i_rst) // R2 R13
		(sel[0] == `PGM_SEL_ALT3 && !i_alt_opendrain[0])
		|-> (o_pad_oe[0] && o_pad_out[0] == i_ext_reg_enable_one))
		else $error("pin0 enable not driven");
	AST_RESET_IN: assert property (@(posedge i_clk) disable iff (i_rst) // R3
		(sel[1] == `PGM_SEL_ALT1) |-> (o_reset_in == sif.clean[1]))
		else $error("reset input not routed");
	AST_WARM_IDLE: assert property (@(posedge i_clk) disable iff (i_rst) // R3
		(sel[1] != `PGM_SEL_ALT2) |-> o_warm_restart_in_n)
		else $error("warm restart active while unrouted");
	AST_SDATA_OE: assert property (@(posedge i_clk) disable iff (i_rst) // R4
		(sel[2] == `PGM_SEL_ALT2 && !i_alt_opendrain[2])
		|-> (o_pad_oe[2] == i_scaling_port_data_oe))
		else $error("scaling data drive not routed");
	AST_SYNC_IDLE: assert property (@(posedge i_clk) disable iff (i_rst) // R5
		(sel[3] != `PGM_SEL_ALT2) |-> !o_converter_sync_clk_in)
		else $error("sync input active while unrouted");
	AST_PIN4_EXTEN: assert property (@(posedge i_clk) disable iff (i_rst) // R6 R13
		(sel[4] == `PGM_SEL_ALT1 && !i_alt_opendrain[4])
		|-> (o_pad_oe[4] && o_pad_out[4] == i_ext_reg_enable_two))
		else $error("pin4 enable not driven");
	AST_SCLK_OE: assert property (@(posedge i_clk) disable iff (i_rst) // R6
		(sel[4] == `PGM_SEL_ALT2 && !i_alt_opendrain[4])
		|-> (o_pad_oe[4] == i_scaling_port_clk_sel_oe))
		else $error("scaling clock drive not routed");
	AST_KEEP_IDLE: assert property (@(posedge i_clk) disable iff (i_rst) // R7
		(sel[5] != `PGM_SEL_ALT1) |-> !o_supply_keep_on_in)
		else $error("keep-on input active while unrouted");
	AST_PIN5_EXTEN: assert property (@(posedge i_clk) disable iff (i_rst) // R7 R13
		(sel[5] == `PGM_SEL_ALT2 && !i_alt_opendrain[5])
		|-> (o_pad_oe[5] && o_pad_out[5] == i_ext_reg_enable_three))
		else $error("pin5 enable not driven");
	AST_RAILS: assert property (@(posedge i_clk) disable iff (i_rst) // R8
		(sel[6] == `PGM_SEL_ALT2 && !i_alt_opendrain[6])
		|-> (o_pad_oe[6] && o_pad_out[6] == i_rails_valid_out))
		else $error("rails valid not driven");
	AST_LOWPWR_IDLE: assert property (@(posedge i_clk) disable iff (i_rst) // R8
		(sel[6] != `PGM_SEL_ALT1) |-> o_low_power_request_n)
		else $error("low-power request active while unrouted");

	// R22 pad drive: primary uses gpio settings, secondary the alt set
	always_comb begin
		for (int i = 0; i < `PGM_NPINS; i++) begin
			if (is_gpio[i]) begin
				if (i_pin_opendrain_select[i]) begin
					o_pad_out[i] = 1'b0; // R21
					o_pad_oe[i] = i_gpio_global_en & dir_r[i] & ~dout_r[i];
				end else begin
					o_pad_out[i] = dout_r[i];
					o_pad_oe[i] = i_gpio_global_en & dir_r[i]; // R19
				end
				o_pad_pull_up[i] = i_pin_pull_config_a[i]; // R20
				o_pad_pull_down[i] = i_pin_pull_config_b[i];
			end else begin
				o_pad_out[i] = i_alt_opendrain[i] ? 1'b0 : alt_out[i];
				o_pad_oe[i] = i_alt_opendrain[i] ? (alt_oe[i] & ~alt_out[i]) : alt_oe[i];
				o_pad_pull_up[i] = i_alt_pull_up[i];
				o_pad_pull_down[i] = i_alt_pull_down[i];
			end
		end
	end
	AST_PULL: assert property (@(posedge i_clk) disable iff (i_rst) // R20
		(is_gpio != 7'h00) |->
		((o_pad_pull_down & is_gpio) == (i_pin_pull_config_b & is_gpio)))
		else $error("gpio pull-down not taken from its config");
	AST_OD: assert property (@(posedge i_clk) disable iff (i_rst) // R21
		(i_pin_opendrain_select != 7'h00) |->
		((o_pad_oe & o_pad_out & is_gpio & i_pin_opendrain_select) == 7'h00))
		else $error("open-drain gpio drove high");
	AST_ALT_PULL: assert property (@(posedge i_clk) disable iff (i_rst) // R22
		(is_gpio != 7'h7f) |->
		((o_pad_pull_up & ~is_gpio) == (i_alt_pull_up & ~is_gpio)))
		else $error("secondary pin pull not from its own set");
	AST_ALT_OD: assert property (@(posedge i_clk) disable iff (i_rst) // R22
		(i_alt_opendrain != 7'h00) |->
		((o_pad_oe & o_pad_out & ~is_gpio & i_alt_opendrain) == 7'h00))
		else $error("open-drain secondary pin drove high");

	assign o_pin_direction = dir_r;
	assign o_data_in = din_r;
	assign o_data_out = dout_r;
	assign o_pin_irq = irq_r;
	assign o_wake_event = wake_r;
	assign o_switch_on_req = on_r;

	AST_SETCLR: assert property (@(posedge i_clk) disable iff (i_rst) // R24
		(i_data_set_we && !i_data_out_we) |=>
		((o_data_out & ~$past(i_data_setclr_wd)) == ($past(o_data_out) & ~$past(i_data_setclr_wd))))
		else $error("set touched other bits");
	AST_NOALTIRQ: assert property (@(posedge i_clk) disable iff (i_rst) // R10
		(!is_gpio[0]) |=> !o_pin_irq[0])
		else $error("irq from secondary pin");
	AST_OFFI2: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		(i_off_mode && (evt & ~`PGM_PIN_I2_MASK) == 7'h00) |=> !o_switch_on_req)
		else $error("io-domain pin switched on from off");
	AST_WAKE: assert property (@(posedge i_clk) disable iff (i_rst) // R11
		(|evt) |=> o_wake_event)
		else $error("event missed wake");
	AST_DIR: assert property (@(posedge i_clk) disable iff (i_rst) // R14
		i_pin_direction_we |=> (o_pin_direction == $past(i_pin_direction_wd)))
		else $error("direction not written");
	AST_CLR: assert property (@(posedge i_clk) disable iff (i_rst) // R17
		(i_data_clr_we && !i_data_set_we && !i_data_out_we) |=>
		((o_data_out & $past(i_data_setclr_wd)) == 7'h00))
		else $error("clear failed");
	AST_GLOBAL: assert property (@(posedge i_clk) disable iff (i_rst) // R19
		(!i_gpio_global_en) |-> ((o_pad_oe & is_gpio) == 7'h00))
		else $error("gpio driven while disabled");
	AST_REGEN: assert property (@(posedge i_clk) disable iff (i_rst) // R13
		(sel[3] == `PGM_SEL_ALT1) |-> (o_pad_oe[3] && (i_alt_opendrain[3] ||
		o_pad_out[3] == i_ext_reg_enable_one)) || (i_alt_opendrain[3]))
		else $error("enable not driven");
endmodule

// file: bench/pgm_board_model.sv
`timescale 1ns/1ps
module pgm_board_model (
	input wire logic i_clk,
	input wire logic [6:0] i_pad_out,
	input wire logic [6:0] i_pad_oe,
	input wire logic [6:0] i_pull_up,
	input wire logic [6:0] i_pull_down,
	input wire logic [6:0] i_ext_val,
	input wire logic [6:0] i_ext_en,
	output logic [6:0] o_pad_in
);
	logic [6:0] float_r = 7'h2a;
	// an unheld, unpulled pad wanders every cycle so no stale level can be relied on
	always @(posedge i_clk) begin
		float_r <= ~float_r;
	end
	// the device wins over the board source, which wins over the pull
	assign o_pad_in = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext_en & i_ext_val)
		| (~i_pad_oe & ~i_ext_en & (i_pull_up | (~i_pull_down & float_r)));
endmodule

// file: bench/pgm_gpio_pin_mux_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module pgm_gpio_pin_mux_test;
	logic i_clk = 0;
	logic i_rst = 1;
	logic i_gpio_global_en = 0;
	logic i_off_mode = 0;
	logic [3:0] st = 4'h0;
	logic [7:0] ao = 8'h0;
	logic [6:0] w = 7'h0, xv = 7'h0, xe = 7'h0;
	logic [6:0] i_pad_role_select_a = 7'h0, i_pad_role_select_b = 7'h0;
	logic [6:0] i_pin_filter_enable = 7'h0, i_pin_pull_config_a = 7'h0;
	logic [6:0] i_pin_pull_config_b = 7'h0, i_pin_opendrain_select = 7'h0;
	logic [6:0] i_alt_pull_up = 7'h0, i_alt_pull_down = 7'h0, i_alt_opendrain = 7'h0;
	logic [6:0] i_irq_rise_edge_select = 7'h0, i_irq_fall_edge_select = 7'h0;
	logic [6:0] i_irq_mask = 7'h0;
	wire i_pin_direction_we, i_data_out_we, i_data_set_we, i_data_clr_we;
	wire [6:0] i_pin_direction_wd, i_data_out_wd, i_data_setclr_wd, i_pad_in;
	wire i_ext_reg_enable_one, i_ext_reg_enable_two, i_ext_reg_enable_three;
	wire i_rails_valid_out, i_scaling_port_data_out, i_scaling_port_data_oe;
	wire i_scaling_port_clk_sel_out, i_scaling_port_clk_sel_oe;
	logic [6:0] o_pad_out, o_pad_oe, o_pad_pull_up, o_pad_pull_down, o_pin_direction;
	logic [6:0] o_data_in, o_data_out, o_pin_irq;
	logic o_wake_event, o_switch_on_req, o_scaling_port_data_in, o_scaling_port_clk_sel_in;
	logic o_power_off_request_in, o_periph_power_req_one, o_periph_power_req_two;
	logic o_reset_in, o_warm_restart_in_n, o_usb_supply_detect_in;
	logic o_converter_sync_clk_in, o_supply_keep_on_in, o_low_power_request_n;
	logic [6:0] q[$];
	logic [31:0] seed = 32'h16;
	int errors = 0;
	int n_compared = 0;
	int son = 0;
	int wk = 0;
	logic [6:0] v, b, e;
	assign {i_data_clr_we, i_data_set_we, i_data_out_we, i_pin_direction_we} = st;
	assign i_pin_direction_wd = w;
	assign i_data_out_wd = w;
	assign i_data_setclr_wd = w;
	assign {i_ext_reg_enable_one, i_ext_reg_enable_two, i_ext_reg_enable_three,
		i_rails_valid_out, i_scaling_port_data_out, i_scaling_port_data_oe,
		i_scaling_port_clk_sel_out, i_scaling_port_clk_sel_oe} = ao;
	always #5 i_clk = ~i_clk;
	pgm_gpio_pin_mux u_pgm_gpio_pin_mux (.i_clk(i_clk), .i_rst(i_rst),
		.i_pad_in(i_pad_in), .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe),
		.o_pad_pull_up(o_pad_pull_up), .o_pad_pull_down(o_pad_pull_down),
		.i_pad_role_select_a(i_pad_role_select_a),
		.i_pad_role_select_b(i_pad_role_select_b),
		.i_pin_direction_we(i_pin_direction_we),
		.i_pin_direction_wd(i_pin_direction_wd), .o_pin_direction(o_pin_direction),
		.o_data_in(o_data_in), .i_data_out_we(i_data_out_we),
		.i_data_out_wd(i_data_out_wd), .o_data_out(o_data_out),
		.i_data_set_we(i_data_set_we), .i_data_clr_we(i_data_clr_we),
		.i_data_setclr_wd(i_data_setclr_wd), .i_pin_filter_enable(i_pin_filter_enable),
		.i_gpio_global_en(i_gpio_global_en), .i_pin_pull_config_a(i_pin_pull_config_a),
		.i_pin_pull_config_b(i_pin_pull_config_b),
		.i_pin_opendrain_select(i_pin_opendrain_select),
		.i_alt_pull_up(i_alt_pull_up), .i_alt_pull_down(i_alt_pull_down),
		.i_alt_opendrain(i_alt_opendrain),
		.i_irq_rise_edge_select(i_irq_rise_edge_select),
		.i_irq_fall_edge_select(i_irq_fall_edge_select), .i_irq_mask(i_irq_mask),
		.i_off_mode(i_off_mode), .o_pin_irq(o_pin_irq), .o_wake_event(o_wake_event),
		.o_switch_on_req(o_switch_on_req),
		.i_ext_reg_enable_one(i_ext_reg_enable_one),
		.i_ext_reg_enable_two(i_ext_reg_enable_two),
		.i_ext_reg_enable_three(i_ext_reg_enable_three),
		.i_rails_valid_out(i_rails_valid_out),
		.i_scaling_port_data_out(i_scaling_port_data_out),
		.i_scaling_port_data_oe(i_scaling_port_data_oe),
		.i_scaling_port_clk_sel_out(i_scaling_port_clk_sel_out),
		.i_scaling_port_clk_sel_oe(i_scaling_port_clk_sel_oe),
		.o_scaling_port_data_in(o_scaling_port_data_in),
		.o_scaling_port_clk_sel_in(o_scaling_port_clk_sel_in),
		.o_power_off_request_in(o_power_off_request_in),
		.o_periph_power_req_one(o_periph_power_req_one),
		.o_periph_power_req_two(o_periph_power_req_two), .o_reset_in(o_reset_in),
		.o_warm_restart_in_n(o_warm_restart_in_n),
		.o_usb_supply_detect_in(o_usb_supply_detect_in),
		.o_converter_sync_clk_in(o_converter_sync_clk_in),
		.o_supply_keep_on_in(o_supply_keep_on_in),
		.o_low_power_request_n(o_low_power_request_n));
	pgm_board_model u_pgm_board_model (.i_clk(i_clk), .i_pad_out(o_pad_out),
		.i_pad_oe(o_pad_oe), .i_pull_up(o_pad_pull_up), .i_pull_down(o_pad_pull_down),
		.i_ext_val(xv), .i_ext_en(xe), .o_pad_in(i_pad_in));
	function automatic logic [6:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[6:0];
	endfunction
	task wr(input int k, input logic [6:0] d);
		@(posedge i_clk);
		st <= 4'(1 << k);
		w <= d;
		@(posedge i_clk);
		st <= 4'h0;
		#1;
	endtask
	task pin(input int p, input logic lv, input logic [6:0] ex);
		@(posedge i_clk);
		xv[p] <= lv;
		if (ex !== 7'h0) q.push_back(ex);
		repeat (8) @(posedge i_clk);
	endtask
	task close_out();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// pulses stand one cycle, so the falling edge sees them settled
	always @(negedge i_clk) begin
		if (!i_rst && o_pin_irq !== 7'h0) begin
			e = (q.size() > 0) ? q.pop_front() : 7'h0;
			`CHK("pin_irq", e, o_pin_irq)
		end
		if (o_switch_on_req === 1'b1) son++;
		if (o_wake_event === 1'b1) wk++;
	end
	initial begin
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		#1;
		`CHK("dout", 7'h0, o_data_out)
		`CHK("dir", 7'h0, o_pin_direction)
		i_gpio_global_en <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			v = rnd();
			wr(1, v);
			`CHK("dout", v, o_data_out)
			b = rnd();
			wr(2, b);
			v = v | b;
			`CHK("set", v, o_data_out)
			b = rnd();
			wr(3, b);
			v = v & ~b;
			`CHK("clr", v, o_data_out)
			wr(0, b);
			`CHK("dir", b, o_pin_direction)
		end
		wr(0, 7'h7f);
		`CHK("oe", 7'h7f, o_pad_oe)
		`CHK("out", v, o_pad_out)
		i_pin_opendrain_select <= 7'h7f;
		@(posedge i_clk);
		#1;
		`CHK("od_oe", ~v, o_pad_oe)
		i_gpio_global_en <= 1'b0;
		@(posedge i_clk);
		#1;
		`CHK("off_oe", 7'h0, o_pad_oe)
		i_gpio_global_en <= 1'b1;
		i_pin_opendrain_select <= 7'h0;
		i_pin_pull_config_a <= v;
		i_pin_pull_config_b <= ~v;
		wr(0, 7'h0);
		`CHK("pu", v, o_pad_pull_up)
		`CHK("pd", ~v, o_pad_pull_down)
		b = rnd();
		xe <= 7'h7f;
		xv <= b;
		repeat (4) @(posedge i_clk);
		#1;
		`CHK("din", b, o_data_in)
		xv <= 7'h0;
		repeat (4) @(posedge i_clk);
		for (int p = 0; p < 7; p++) begin
			b = 7'(1 << p);
			for (int m = 1; m < 4; m++) begin
				i_irq_rise_edge_select <= m[0] ? b : 7'h0;
				i_irq_fall_edge_select <= m[1] ? b : 7'h0;
				pin(p, 1'b1, m[0] ? b : 7'h0);
				pin(p, 1'b0, m[1] ? b : 7'h0);
			end
			i_irq_mask <= b;
			pin(p, 1'b1, 7'h0);
			pin(p, 1'b0, 7'h0);
			i_irq_mask <= 7'h0;
			i_pad_role_select_a <= b;
			pin(p, 1'b1, 7'h0);
			pin(p, 1'b0, 7'h0);
			i_pad_role_select_a <= 7'h0;
		end
		`CHK("irq_q", 0, q.size())
		i_irq_rise_edge_select <= 7'h7f;
		i_irq_fall_edge_select <= 7'h0;
		i_off_mode <= 1'b1;
		son = 0;
		wk = 0;
		pin(2, 1'b1, 7'h04);
		pin(4, 1'b1, 7'h10);
		`CHK("son_io", 0, son)
		`CHK("wake", 1'b1, wk > 0)
		pin(0, 1'b1, 7'h01);
		`CHK("son_0", 1'b1, son > 0)
		i_off_mode <= 1'b0;
		// role switches move pad levels, so keep events masked meanwhile
		i_irq_mask <= 7'h7f;
		ao <= {rnd(), 1'b0};
		v = rnd();
		i_alt_pull_up <= v;
		i_alt_pull_down <= ~v;
		i_pad_role_select_a <= 7'h1f;
		i_pad_role_select_b <= 7'h61;
		b = rnd();
		xe <= 7'h06;
		xv <= b;
		repeat (4) @(posedge i_clk);
		#1;
		`CHK("alt_pu", v, o_pad_pull_up)
		`CHK("alt_oe", 7'h79, o_pad_oe & 7'h79)
		`CHK("alt_out", {ao[4], ao[5], ao[6], ao[7], 2'b0, ao[7]}, o_pad_out & 7'h79)
		`CHK("rst_in", b[1], o_reset_in)
		`CHK("req2", b[2], o_periph_power_req_two)
		i_pad_role_select_a <= 7'h61;
		i_pad_role_select_b <= 7'h0a;
		b = rnd();
		xe <= 7'h6b;
		xv <= b;
		repeat (4) @(posedge i_clk);
		#1;
		`CHK("pwr_off", b[0], o_power_off_request_in)
		`CHK("warm", b[1], o_warm_restart_in_n)
		`CHK("sync", b[3], o_converter_sync_clk_in)
		`CHK("keep", b[5], o_supply_keep_on_in)
		`CHK("sleep", b[6], o_low_power_request_n)
		i_pad_role_select_a <= 7'h02;
		i_pad_role_select_b <= 7'h16;
		b = rnd();
		xe <= 7'h7f;
		xv <= b;
		repeat (4) @(posedge i_clk);
		#1;
		`CHK("usb", b[1], o_usb_supply_detect_in)
		`CHK("req1", 1'b0, o_periph_power_req_one)
		`CHK("sd_oe", ao[2], o_pad_oe[2])
		`CHK("sd_in", ao[2] ? ao[3] : b[2], o_scaling_port_data_in)
		`CHK("sc_in", b[4], o_scaling_port_clk_sel_in)
		i_pad_role_select_a <= 7'h0;
		i_pad_role_select_b <= 7'h0;
		i_irq_rise_edge_select <= 7'h01;
		i_pin_filter_enable <= 7'h01;
		xe <= 7'h7f;
		xv <= 7'h0;
		repeat (8) @(posedge i_clk);
		i_irq_mask <= 7'h0;
		pin(0, 1'b1, 7'h0);
		xv[0] <= 1'b0;
		repeat (1100) @(posedge i_clk);
		xv[0] <= 1'b1;
		q.push_back(7'h01);
		for (int i = 0; i < 1100 && q.size() > 0; i++) @(posedge i_clk);
		`CHK("deb_q", 0, q.size())
		close_out();
	end
endmodule
